// >>> logic/dcd_pkg.sv
/*
  shared constants and types of the command decoder pair.
  assumes one 250 MHz clock shared by both ends.
*/
`default_nettype none
package dcd_pkg;
  localparam int BANK_W  = 3;
  localparam int NBANK   = 8;
  localparam int ADDR_W  = 13;
  localparam int ROW_W   = 13;
  localparam int AP_BIT  = 10;
  localparam int BC_BIT  = 12;
  localparam int MR_W    = 2;

  typedef enum logic [3:0] {
    DCD_CMD_NONE  = 4'h0,
    DCD_CMD_ACT   = 4'h1,
    DCD_CMD_PRE   = 4'h2,
    DCD_CMD_PREA  = 4'h3,
    DCD_CMD_RD    = 4'h4,
    DCD_CMD_WR    = 4'h5,
    DCD_CMD_MRS   = 4'h6,
    DCD_CMD_REF   = 4'h7,
    DCD_CMD_SRE   = 4'h8,
    DCD_CMD_PDE   = 4'h9,
    DCD_CMD_EXIT  = 4'hA,
    DCD_CMD_ZQL   = 4'hB,
    DCD_CMD_ZQS   = 4'hC,
    DCD_CMD_NOP   = 4'hD
  } dcd_cmd_t;

  typedef enum logic [1:0] {
    DCD_PWR_ON    = 2'h0,
    DCD_PWR_PD    = 2'h1,
    DCD_PWR_SR    = 2'h2
  } dcd_pwr_t;
endpackage
`default_nettype wire

// >>> logic/dcd_if.sv
/*
  command pins between controller and decoder.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface dcd_if;
  import dcd_pkg::*;
  logic                cke;
  logic                cs_n;
  logic                ras_n;
  logic                cas_n;
  logic                we_n;
  logic [BANK_W-1:0]   ba;
  logic [ADDR_W-1:0]   addr;
  logic [1:0]          dm;
  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm);
  modport dev  (input  cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm);
endinterface
`default_nettype wire

// >>> logic/dcd_ctrl.sv
/*
  controller end: registers one user command onto the pins per clock.
  assumes the user keeps to bank states and timing itself.
*/
`timescale 1ns/1ps
`default_nettype none
module dcd_ctrl
  import dcd_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_valid,
  input  var  dcd_cmd_t          i_cmd,
  input  wire logic [BANK_W-1:0] i_ba,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [1:0]        i_dm,
  dcd_if.ctrl                    pins
);
  logic              cke_reg;
  logic [3:0]        code_reg;
  logic [BANK_W-1:0] ba_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [1:0]        dm_reg;
  logic [3:0]        code_next;
  logic              cke_next;

  // cs ras cas we
  always_comb begin
    code_next = 4'h8;
    cke_next  = cke_reg;
    if (i_valid) begin
      case (i_cmd)
        DCD_CMD_ACT:  code_next = 4'h3;
        DCD_CMD_PRE,
        DCD_CMD_PREA: code_next = 4'h2;
        DCD_CMD_RD:   code_next = 4'h5;
        DCD_CMD_WR:   code_next = 4'h4;
        DCD_CMD_MRS:  code_next = 4'h0;
        DCD_CMD_REF:  code_next = 4'h1;
        DCD_CMD_SRE: begin
          code_next = 4'h1;
          cke_next  = 1'b0;
        end
        DCD_CMD_PDE: begin
          code_next = 4'h7;
          cke_next  = 1'b0;
        end
        DCD_CMD_EXIT: begin
          code_next = 4'h7;
          cke_next  = 1'b1;
        end
        DCD_CMD_ZQL,
        DCD_CMD_ZQS:  code_next = 4'h6;
        DCD_CMD_NOP:  code_next = 4'h7;
        default:      code_next = 4'h8;
      endcase
    end
  end

  wire [ADDR_W-1:0] addr_fix =
    (i_cmd == DCD_CMD_PREA || i_cmd == DCD_CMD_ZQL) ? (i_addr | 13'h0400) :
    (i_cmd == DCD_CMD_PRE  || i_cmd == DCD_CMD_ZQS) ? (i_addr & 13'h1BFF) : i_addr;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cke_reg  <= 1'b1;
      code_reg <= 4'hF;
      ba_reg   <= '0;
      addr_reg <= '0;
      dm_reg   <= '0;
    end else begin
      cke_reg  <= cke_next;
      code_reg <= code_next;
      ba_reg   <= i_ba;
      addr_reg <= addr_fix;
      dm_reg   <= i_dm;
    end
  end

  assign pins.cke   = cke_reg;
  assign pins.cs_n  = code_reg[3];
  assign pins.ras_n = code_reg[2];
  assign pins.cas_n = code_reg[1];
  assign pins.we_n  = code_reg[0];
  assign pins.ba    = ba_reg;
  assign pins.addr  = addr_reg;
  assign pins.dm    = dm_reg;
endmodule
`default_nettype wire

// >>> logic/dcd_dev.sv
/*
  device end: decodes command pins, tracks eight banks and power state.
  assumes pins are synchronous to i_ref_clk, sampled on its rising edge.
*/
// Notes on behaviour
// - activate opens row in idle bank
// - row stays open until bank precharged
// - precharge one bank, or all when A10 high
// - controller waits row precharge time before activate; dcd_ctrl leaves it to the user
// - precharged bank idle; activate before column access
// - precharge to idle bank is accepted
// - controller keeps auto precharge transfers uninterrupted; dcd_ctrl leaves it to the user
// - column access on active bank; WE selects
// - A10 on read/write requests auto precharge
// - A12 picks chop or eight when enabled
// - all low with banks idle sets mode
// - no-operation registers no new command
// - chip deselected ignores all command inputs
// - refresh; with CKE falling enters self refresh
// - CKE falling on nop/deselect enters power-down
// - CKE rising on nop/deselect exits low power
// - ZQ calibration, A10 selects long or short
// - high data mask blocks write byte lanes
// - commands qualified by previous and current CKE
// - bank state checked at command bank address
// - inputs sampled on rising clock edge
// - bank address selects target mode register
`timescale 1ns/1ps
`default_nettype none
module dcd_dev
  import dcd_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_otf_en,
  dcd_if.dev                     pins,
  output var  dcd_cmd_t          o_cmd,
  output logic [BANK_W-1:0]      o_bank,
  output logic [ROW_W-1:0]       o_addr,
  output logic                   o_auto_pre,
  output logic                   o_chop,
  output logic [1:0]             o_wr_lane_en,
  output logic [MR_W-1:0]        o_mr_sel,
  output logic [NBANK-1:0]       o_bank_open,
  output logic [ROW_W-1:0]       o_open_row [NBANK],
  output var  dcd_pwr_t          o_pwr,
  output logic                   o_err
);
  logic              cke_prev_reg;
  logic [NBANK-1:0]  open_reg;
  logic [ROW_W-1:0]  row_reg [NBANK];
  dcd_pwr_t          pwr_reg;
  dcd_cmd_t          cmd_reg;
  logic [BANK_W-1:0] bank_reg;
  logic [ROW_W-1:0]  addr_reg;
  logic              ap_reg;
  logic              chop_reg;
  logic [1:0]        lane_reg;
  logic [MR_W-1:0]   mr_reg;
  logic              err_reg;

  // command decode from the pins taken at this edge
  wire       sel     = ~pins.cs_n;
  wire [2:0] rcw     = {pins.ras_n, pins.cas_n, pins.we_n};
  wire       cke_hh  = cke_prev_reg & pins.cke;
  wire       cke_hl  = cke_prev_reg & ~pins.cke;
  wire       cke_lh  = ~cke_prev_reg & pins.cke;
  wire       all_idl = ~|open_reg;
  wire       b_open  = open_reg[pins.ba];
  wire       a10     = pins.addr[AP_BIT];
  wire       nop_des = ~sel | (rcw == 3'h7);
  wire       on      = (pwr_reg == DCD_PWR_ON);
  wire       is_act  = on & cke_hh & sel & (rcw == 3'h3);
  wire       is_pre  = on & cke_hh & sel & (rcw == 3'h2);
  wire       is_col  = on & cke_hh & sel & (rcw[2:1] == 2'h2);
  wire       is_mrs  = on & cke_hh & sel & (rcw == 3'h0);
  wire       is_ref  = on & sel & (rcw == 3'h1);
  wire       is_zq   = on & cke_hh & sel & (rcw == 3'h6);
  wire       pd_in   = on & cke_hl & nop_des;
  wire       lp_out  = ~on & cke_lh & nop_des;
  wire       act_ok  = is_act & ~b_open;
  wire       col_ok  = is_col & b_open;
  wire       bad     = (is_act & b_open) | (is_col & ~b_open)
                     | ((is_mrs | is_ref | is_zq) & ~all_idl);

  // A10 picks the all-bank or long form of precharge and calibration
  function automatic dcd_cmd_t pick_a10(input logic     hi,
                                       input dcd_cmd_t wide,
                                       input dcd_cmd_t narrow);
    return hi ? wide : narrow;
  endfunction

  // accepted command: low-power moves first, then refusals
  dcd_cmd_t cmd_next;
  always_comb begin
    cmd_next = DCD_CMD_NONE;
    if (lp_out) begin
      cmd_next = DCD_CMD_EXIT;
    end else if (pd_in) begin
      cmd_next = DCD_CMD_PDE;
    end else if (bad) begin
      cmd_next = DCD_CMD_NONE;
    end else if (act_ok) begin
      cmd_next = DCD_CMD_ACT;
    end else if (is_pre) begin
      cmd_next = pick_a10(a10, DCD_CMD_PREA, DCD_CMD_PRE);
    end else if (col_ok) begin
      cmd_next = pins.we_n ? DCD_CMD_RD : DCD_CMD_WR;
    end else if (is_mrs) begin
      cmd_next = DCD_CMD_MRS;
    end else if (is_ref & cke_hh) begin
      cmd_next = DCD_CMD_REF;
    end else if (is_ref & cke_hl) begin
      cmd_next = DCD_CMD_SRE;
    end else if (is_zq) begin
      cmd_next = pick_a10(a10, DCD_CMD_ZQL, DCD_CMD_ZQS);
    end
  end

  // qualifiers that travel with the decoded command
  wire       wr_go     = col_ok & ~pins.we_n;
  wire       ap_next   = col_ok & a10;
  wire       chop_next = col_ok & i_otf_en & ~pins.addr[BC_BIT];
  wire [1:0] lane_next = wr_go ? ~pins.dm : 2'h0;
  wire       mrs_go    = (cmd_next == DCD_CMD_MRS);
  dcd_pwr_t  pwr_next;
  assign pwr_next = lp_out ? DCD_PWR_ON :
                    pd_in  ? DCD_PWR_PD :
                    (cmd_next == DCD_CMD_SRE) ? DCD_PWR_SR : pwr_reg;

  // bank row tracking
  genvar g;
  generate
    for (g = 0; g < NBANK; g++) begin : g_bank
      wire hit  = (pins.ba == BANK_W'(g));
      wire opn  = (cmd_next == DCD_CMD_ACT) & hit;
      wire shut = (cmd_next == DCD_CMD_PREA) | ((cmd_next == DCD_CMD_PRE) & hit)
                | (col_ok & a10 & hit);
      always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          open_reg[g] <= 1'b0;
          row_reg[g]  <= '0;
        end else if (opn) begin
          open_reg[g] <= 1'b1;
          row_reg[g]  <= pins.addr;
        end else if (shut) begin
          open_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // power state and the previous CKE sample
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cke_prev_reg <= 1'b1;
      pwr_reg      <= DCD_PWR_ON;
    end else begin
      cke_prev_reg <= pins.cke;
      pwr_reg      <= pwr_next;
    end
  end

  // decoded command and its qualifiers, each for one cycle
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cmd_reg  <= DCD_CMD_NONE;
      bank_reg <= '0;
      addr_reg <= '0;
      ap_reg   <= 1'b0;
      chop_reg <= 1'b0;
      lane_reg <= 2'h0;
      err_reg  <= 1'b0;
    end else begin
      cmd_reg  <= cmd_next;
      bank_reg <= pins.ba;
      addr_reg <= pins.addr;
      ap_reg   <= ap_next;
      chop_reg <= chop_next;
      lane_reg <= lane_next;
      err_reg  <= bad;
    end
  end

  // mode register target, held until the next accepted mode set
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mr_reg <= '0;
    end else if (mrs_go) begin
      mr_reg <= pins.ba[MR_W-1:0];
    end
  end

  // every output straight from its flop
  assign o_cmd        = cmd_reg;
  assign o_bank       = bank_reg;
  assign o_addr       = addr_reg;
  assign o_auto_pre   = ap_reg;
  assign o_chop       = chop_reg;
  assign o_wr_lane_en = lane_reg;
  assign o_mr_sel     = mr_reg;
  assign o_bank_open  = open_reg;
  assign o_open_row   = row_reg;
  assign o_pwr        = pwr_reg;
  assign o_err        = err_reg;
endmodule
`default_nettype wire

// >>> sim/dcd_assertions.sv
/*
  checker on the command pins and the device outputs of the decoder pair.
  assumes one clock, async active-high reset, ctrl holding cke high in reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dcd_chk
  import dcd_pkg::*;
(
  input wire logic              i_ref_clk,
  input wire logic              i_sys_rst,
  input wire logic              cke,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [1:0]        dm,
  input wire logic              i_otf_en,
  input var  dcd_cmd_t          o_cmd,
  input wire logic [NBANK-1:0]  o_bank_open,
  input wire logic              o_auto_pre,
  input wire logic              o_chop,
  input wire logic [1:0]        o_wr_lane_en,
  input wire logic [MR_W-1:0]   o_mr_sel,
  input var  dcd_pwr_t          o_pwr,
  input wire logic              o_err
);
  logic       cke_reg;
  wire        pon  = (o_pwr == DCD_PWR_ON);
  wire        on   = pon && cke && cke_reg && !cs_n;
  wire  [2:0] rcw  = {ras_n, cas_n, we_n};
  wire        opn  = o_bank_open[ba];
  wire        idle = (o_bank_open == 8'h00);
  wire        col  = on && ras_n && !cas_n;
  wire        nopd = cs_n || (rcw == 3'h7);
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cke_reg <= 1'b1;
    end else begin
      cke_reg <= cke;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  AST_ACT: assert property (on && rcw == 3'h3 && !opn |=>
    o_cmd == DCD_CMD_ACT && o_bank_open[$past(ba)]) else $error("activate lost");
  AST_ACT_OPEN: assert property (on && rcw == 3'h3 && opn |=>
    o_err && $stable(o_bank_open)) else $error("activate on open bank ran");
  AST_PRE: assert property (on && rcw == 3'h2 |=> o_bank_open ==
    ($past(addr[AP_BIT]) ? 8'h00 : $past(o_bank_open) & ~(8'h01 << $past(ba))))
    else $error("precharge wrong");
  AST_COL_IDLE: assert property (col && !opn |=> o_err) else $error("idle access ran");
  AST_COL: assert property (col && opn |=>
    o_cmd == ($past(we_n) ? DCD_CMD_RD : DCD_CMD_WR) && o_auto_pre == $past(addr[AP_BIT])
    && o_chop == ($past(i_otf_en) && !$past(addr[BC_BIT]))) else $error("column wrong");
  AST_LANE: assert property (col && opn && !we_n |=> o_wr_lane_en == ~$past(dm))
    else $error("lane enable wrong");
  AST_MRS: assert property (on && rcw == 3'h0 && idle |=> o_cmd == DCD_CMD_MRS
    && o_mr_sel == $past(ba[1:0])) else $error("mode set wrong");
  AST_ZQ: assert property (on && rcw == 3'h6 && idle |=> o_cmd ==
    ($past(addr[AP_BIT]) ? DCD_CMD_ZQL : DCD_CMD_ZQS)) else $error("zq wrong");
  AST_DESEL: assert property (pon && cke && cke_reg && cs_n |=>
    o_cmd == DCD_CMD_NONE && !o_err && $stable(o_bank_open)) else $error("deselect acted");
  AST_PD: assert property (pon && cke_reg && !cke && nopd |=> o_pwr == DCD_PWR_PD)
    else $error("no power-down");
  AST_EXIT: assert property (!pon && !cke_reg && cke && nopd |=> pon)
    else $error("no exit");
  AST_SRE: assert property (pon && cke_reg && !cke && !cs_n && rcw == 3'h1 && idle
    |=> o_pwr == DCD_PWR_SR) else $error("no self refresh");
  cover property (on && rcw == 3'h3);
  cover property (o_pwr == DCD_PWR_SR);
  cover property (o_err);
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
/*
  bench joining controller and device end by dcd_if, with the checker.
  assumes a 250 MHz clock and async active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dcd_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              vld = 1'b0;
  logic              otf = 1'b1;
  dcd_cmd_t          cmd = DCD_CMD_NONE;
  logic [BANK_W-1:0] ba = 3'h0;
  logic [ADDR_W-1:0] ad = 13'h0000;
  logic [1:0]        dm = 2'h0;
  dcd_cmd_t          o_cmd;
  dcd_pwr_t          pwr;
  logic              ap, bc, err;
  logic [1:0]        ln, mr;
  logic [NBANK-1:0]  opn;
  logic [BANK_W-1:0] obk;
  logic [ROW_W-1:0]  oad;
  logic [ROW_W-1:0]  row [NBANK];
  int                err_total = 0;
  int                checks_done = 0;
  always #2 clk = ~clk;
  dcd_if p();
  dcd_ctrl i_dcd_ctrl (.i_ref_clk(clk), .i_sys_rst(rst), .i_valid(vld), .i_cmd(cmd),
    .i_ba(ba), .i_addr(ad), .i_dm(dm), .pins(p.ctrl));
  dcd_dev i_dcd_dev (.i_ref_clk(clk), .i_sys_rst(rst), .i_otf_en(otf), .pins(p.dev),
    .o_cmd(o_cmd), .o_bank(obk), .o_addr(oad), .o_auto_pre(ap), .o_chop(bc),
    .o_wr_lane_en(ln), .o_mr_sel(mr), .o_bank_open(opn), .o_open_row(row), .o_pwr(pwr),
    .o_err(err));
  dcd_chk i_dcd_chk (.i_ref_clk(clk), .i_sys_rst(rst), .cke(p.cke), .cs_n(p.cs_n),
    .ras_n(p.ras_n), .cas_n(p.cas_n), .we_n(p.we_n), .ba(p.ba), .addr(p.addr), .dm(p.dm),
    .i_otf_en(otf), .o_cmd(o_cmd), .o_bank_open(opn), .o_auto_pre(ap), .o_chop(bc),
    .o_wr_lane_en(ln), .o_mr_sel(mr), .o_pwr(pwr), .o_err(err));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic run(input dcd_cmd_t c, input logic [2:0] b, input logic [12:0] a,
                     input logic [1:0] m, input dcd_cmd_t ec, input logic ee);
    @(posedge clk);
    cmd <= c;
    ba <= b;
    ad <= a;
    dm <= m;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    @(posedge clk);
    #1;
    chk("cmd", 16'(ec), 16'(o_cmd));
    chk("err", 16'(ee), 16'(err));
    chk("bank", 16'(b), 16'(obk));
  endtask
  task automatic t_act;
    run(DCD_CMD_ACT, 3'h2, 13'h1ABC, 2'h0, DCD_CMD_ACT, 1'b0);
    chk("addr", 16'h1ABC, 16'(oad));
    chk("row", 16'h1ABC, 16'(row[2]));
    run(DCD_CMD_ACT, 3'h2, 13'h0123, 2'h0, DCD_CMD_NONE, 1'b1);
    chk("row", 16'h1ABC, 16'(row[2]));
  endtask
  task automatic t_col;
    run(DCD_CMD_RD, 3'h2, 13'h0000, 2'h0, DCD_CMD_RD, 1'b0);
    chk("chop", 16'h0001, 16'(bc));
    chk("ap", 16'h0000, 16'(ap));
    @(posedge clk);
    otf <= 1'b0;
    run(DCD_CMD_WR, 3'h2, 13'h0400, 2'h1, DCD_CMD_WR, 1'b0);
    chk("lane", 16'h0002, 16'(ln));
    chk("chop", 16'h0000, 16'(bc));
    chk("ap", 16'h0001, 16'(ap));
    run(DCD_CMD_RD, 3'h2, 13'h0000, 2'h0, DCD_CMD_NONE, 1'b1);
  endtask
  task automatic t_pre;
    run(DCD_CMD_ACT, 3'h1, 13'h0011, 2'h0, DCD_CMD_ACT, 1'b0);
    run(DCD_CMD_ACT, 3'h3, 13'h0033, 2'h0, DCD_CMD_ACT, 1'b0);
    run(DCD_CMD_PRE, 3'h1, 13'h0000, 2'h0, DCD_CMD_PRE, 1'b0);
    chk("open", 16'h0008, 16'(opn));
    run(DCD_CMD_PRE, 3'h1, 13'h0000, 2'h0, DCD_CMD_PRE, 1'b0);
    run(DCD_CMD_MRS, 3'h0, 13'h0000, 2'h0, DCD_CMD_NONE, 1'b1);
    run(DCD_CMD_NOP, 3'h0, 13'h0000, 2'h0, DCD_CMD_NONE, 1'b0);
    run(DCD_CMD_PREA, 3'h0, 13'h0000, 2'h0, DCD_CMD_PREA, 1'b0);
    chk("open", 16'h0000, 16'(opn));
  endtask
  task automatic t_ap;
    repeat (4) @(posedge clk);
    otf <= 1'b1;
    run(DCD_CMD_ACT, 3'h1, 13'h0055, 2'h0, DCD_CMD_ACT, 1'b0);
    run(DCD_CMD_ACT, 3'h4, 13'h0044, 2'h0, DCD_CMD_ACT, 1'b0);
    run(DCD_CMD_WR, 3'h1, 13'h0400, 2'h3, DCD_CMD_WR, 1'b0);
    chk("lane", 16'h0000, 16'(ln));
    chk("open", 16'h0010, 16'(opn));
    run(DCD_CMD_RD, 3'h4, 13'h1000, 2'h0, DCD_CMD_RD, 1'b0);
    chk("chop", 16'h0000, 16'(bc));
    chk("ap", 16'h0000, 16'(ap));
    run(DCD_CMD_PREA, 3'h0, 13'h0000, 2'h0, DCD_CMD_PREA, 1'b0);
  endtask
  task automatic t_mode;
    run(DCD_CMD_MRS, 3'h2, 13'h0008, 2'h0, DCD_CMD_MRS, 1'b0);
    chk("mr", 16'h0002, 16'(mr));
    run(DCD_CMD_ZQL, 3'h0, 13'h0000, 2'h0, DCD_CMD_ZQL, 1'b0);
    run(DCD_CMD_ZQS, 3'h0, 13'h0000, 2'h0, DCD_CMD_ZQS, 1'b0);
  endtask
  task automatic t_pwr;
    run(DCD_CMD_REF, 3'h0, 13'h0000, 2'h0, DCD_CMD_REF, 1'b0);
    run(DCD_CMD_SRE, 3'h0, 13'h0000, 2'h0, DCD_CMD_SRE, 1'b0);
    chk("pwr", 16'(DCD_PWR_SR), 16'(pwr));
    run(DCD_CMD_EXIT, 3'h0, 13'h0000, 2'h0, DCD_CMD_EXIT, 1'b0);
    run(DCD_CMD_PDE, 3'h0, 13'h0000, 2'h0, DCD_CMD_PDE, 1'b0);
    chk("pwr", 16'(DCD_PWR_PD), 16'(pwr));
    run(DCD_CMD_EXIT, 3'h0, 13'h0000, 2'h0, DCD_CMD_EXIT, 1'b0);
    chk("pwr", 16'(DCD_PWR_ON), 16'(pwr));
  endtask
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_act();
    t_col();
    t_pre();
    t_ap();
    t_mode();
    t_pwr();
    wrap_up();
  end
endmodule
`default_nettype wire
